/* File: bench/ccr_host.sv */
/*
 * Behavioural two-wire bus master in place of the host processor.
 * Assumes the bench resolves the open-drain data wire and feeds it back on sda.
 */
`timescale 1ns/1ns
module ccr_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // data moves only while scl is low; long low phase lets the slave let go first
    task automatic bitx(input logic b, output logic r);
        sda_low <= ~b;
        wt(2);
        scl <= 1'b1;
        wt(3);
        r = sda;
        scl <= 1'b0;
        wt(2);
    endtask

    task automatic start();
        sda_low <= 1'b0;
        wt(2);
        scl <= 1'b1;
        wt(3);
        sda_low <= 1'b1;
        wt(3);
        scl <= 1'b0;
        wt(2);
    endtask

    task automatic stop();
        sda_low <= 1'b1;
        wt(2);
        scl <= 1'b1;
        wt(3);
        sda_low <= 1'b0;
        wt(3);
    endtask

    // msb first, ninth bit released for the acknowledge
    task automatic xbyte(input logic [7:0] d, output logic [7:0] r, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], b);
            r[i] = b;
        end
        bitx(1'b1, b);
        ack = ~b;
    endtask
endmodule

/* File: bench/ccr_regs_tb_top.sv */
/*
 * Self-checking bench for the charger configuration registers.
 * Assumes the host model drives the serial pins; the open-drain wire is resolved here.
 */
`timescale 1ns/1ns
module ccr_regs_tb_top;
    import ccr_pkg::*;
    localparam logic [31:0] WDU = 32'h000007D0;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic dis = 1'b1;
    logic scl, hlow, sda_oe, sda_out, wdf, a;
    wire sda = ~(sda_oe | hlow);
    ccr_cfg_t cfg;
    logic [7:0] v, w;
    logic [7:0] dflt [4] = '{8'h0F, 8'h91, 8'hA3, 8'h7A};
    logic [7:0] ctab [4] = '{8'h37, 8'h38, 8'h39, 8'h3F};
    int err_count = 0;
    int cmp_count = 0;

    always #25 clk = ~clk;

    ccr_host host_u (.clk(clk), .sda(sda), .scl(scl), .sda_low(hlow));
    ccr_regs #(.WD_UNIT_CYCLES(WDU)) dut_u (.CORE_CLK(clk), .RST_B(rst_b), .SCL(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .DISCHARGING(dis), .CFG(cfg), .WD_FAULT(wdf));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    // config packs as the six-bit current code and the other three register bytes; only the current code is clamped
    function automatic ccr_cfg_t cfg_of(input logic [7:0] c, d, vv, ww);
        return {(c[5:0] > 6'h38) ? 6'h38 : c[5:0], d, vv, ww};
    endfunction

    task automatic ccfg(input logic [7:0] c, d, vv, ww);
        chk("cfg", 32'(cfg), 32'(cfg_of(c, d, vv, ww)));
    endtask

    task automatic head(input logic [7:0] ofs);
        logic [7:0] r;
        logic a0, a1;
        host_u.start();
        host_u.xbyte(8'h06, r, a0);
        host_u.xbyte(ofs, r, a1);
        chk("ack head", 32'({a0, a1, sda_out}), 32'h6);
    endtask

    // accesses follow each other far inside the period
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic [7:0] r;
        logic ak;
        head(ofs);
        host_u.xbyte(d, r, ak);
        host_u.stop();
        chk("ack data", 32'(ak), 32'h1);
    endtask

    task automatic rchk(input logic [7:0] ofs, input logic [7:0] exp);
        logic ak;
        head(ofs);
        host_u.start();
        host_u.xbyte(8'h07, v, ak);
        chk("ack read", 32'(ak), 32'h1);
        host_u.xbyte(8'hFF, v, ak);
        host_u.stop();
        chk("reg", 32'(v), 32'(exp));
    endtask

    // two bytes each way in one transfer; master ack keeps the read going
    task automatic burst(input logic [7:0] ofs, input logic [7:0] d0, input logic [7:0] d1);
        logic [7:0] r;
        logic b, k0, k1;
        head(ofs);
        host_u.xbyte(d0, r, k0);
        host_u.xbyte(d1, r, k1);
        host_u.stop();
        chk("ack burst", 32'({k0, k1}), 32'h3);
        head(ofs);
        host_u.start();
        host_u.xbyte(8'h07, r, k0);
        chk("ack burst read", 32'(k0), 32'h1);
        for (int i = 7; i >= 0; i--) begin
            host_u.bitx(1'b1, b);
            r[i] = b;
        end
        host_u.bitx(1'b0, b);
        host_u.xbyte(8'hFF, v, k1);
        host_u.stop();
        chk("burst first", 32'(r), 32'(d0));
        chk("burst second", 32'(v), 32'(d1));
    endtask

    task automatic defaults();
        for (int i = 0; i < 4; i++) begin
            rchk(8'h02 + 8'(i), dflt[i]);
        end
        ccfg(8'h0F, 8'h91, 8'hA3, 8'h7A);
    endtask

    // deliberate silence longer than the shortest period
    task automatic idle_fault(input logic exp);
        host_u.wt(2500);
        chk("fault", 32'(wdf), 32'(exp));
    endtask

    task automatic tend(input string s);
        $display("test %s done", s);
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        defaults();
        chk("fault", 32'(wdf), 32'h0);
        tend("defaults");
        foreach (ctab[i]) begin
            wr(8'h02, ctab[i]);
            rchk(8'h02, ctab[i]);
            ccfg(ctab[i], 8'h91, 8'hA3, 8'h7A);
        end
        wr(8'h02, 8'h4F);
        rchk(8'h02, 8'h0F);
        tend("current");
        wr(8'h03, 8'h05);
        rchk(8'h03, 8'h95);
        wr(8'h04, 8'h55);
        rchk(8'h04, 8'h55);
        ccfg(8'h0F, 8'h95, 8'h55, 8'h7A);
        for (int i = 0; i < 4; i++) begin
            w = {1'b0, 2'(i), i[0], i[1], 2'(i), i[0]};
            wr(8'h05, w);
            rchk(8'h05, w);
            ccfg(8'h0F, 8'h95, 8'h55, w);
        end
        tend("fields");
        wr(8'h0A, 8'h5A);
        rchk(8'h0A, 8'h00);
        host_u.start();
        host_u.xbyte(8'h20, v, a);
        host_u.stop();
        chk("ack stranger", 32'(a), 32'h0);
        tend("refusals");
        wr(8'h05, 8'h3A);
        idle_fault(1'b0);
        wr(8'h05, 8'h80);
        idle_fault(1'b0);
        wr(8'h02, 8'h20);
        wr(8'h05, 8'hA0);
        idle_fault(1'b1);
        ccfg(8'h0F, 8'h91, 8'hA3, 8'hBA);
        rchk(8'h05, 8'hBA);
        rchk(8'h08, 8'h80);
        rchk(8'h08, 8'h00);
        tend("watchdog");
        burst(8'h03, 8'h22, 8'h60);
        wr(8'h02, 8'h80);
        defaults();
        tend("soft reset");
        dis <= 1'b0;
        wr(8'h05, 8'h5A);
        idle_fault(1'b0);
        host_u.wt(1700);
        chk("fault", 32'(wdf), 32'h1);
        tend("long period");
        rchk(8'h08, 8'h80);
        wr(8'h05, 8'h7A);
        host_u.wt(7600);
        chk("fault", 32'(wdf), 32'h0);
        host_u.wt(600);
        chk("fault", 32'(wdf), 32'h1);
        tend("longest period");
        stop_test();
    end
endmodule

/* File: hw/ccr_pkg.sv */
/*
 * Package for the charger configuration register block: offsets, field
 * positions, reset values, watchdog timing, carrier structs and serial states.
 * Assumes a single core clock at the rate given below.
 */
package ccr_pkg;
    localparam logic [6:0] CCR_SLAVE_ADDR = 7'h03;
    localparam logic [7:0] CCR_OFS_CHG = 8'h02;
    localparam logic [7:0] CCR_OFS_DTERM = 8'h03;
    localparam logic [7:0] CCR_OFS_VOLT = 8'h04;
    localparam logic [7:0] CCR_OFS_WDT = 8'h05;
    localparam logic [7:0] CCR_OFS_STAT = 8'h08;
    localparam logic [7:0] CCR_RST_CHG = 8'h0F;
    localparam logic [7:0] CCR_RST_DTERM = 8'h91;
    localparam logic [7:0] CCR_RST_VOLT = 8'hA3;
    localparam logic [7:0] CCR_RST_WDT = 8'h7A;
    localparam int CCR_SWRST_BIT = 7;
    localparam int CCR_KICK_BIT = 6;
    localparam int CCR_FAULT_BIT = 7;
    localparam int CCR_WDDIS_BIT = 7;
    localparam int CCR_WDPER_LSB = 5;
    localparam int CCR_TERM_BIT = 4;
    localparam int CCR_TIMER_BIT = 3;
    localparam int CCR_CTIME_LSB = 1;
    localparam int CCR_KEEP_BIT = 0;
    localparam logic [5:0] CCR_ICHG_MAX = 6'h38;
    localparam logic [3:0] CCR_DLIM_BAD = 4'h0;
    // watchdog base period and core rate
    localparam longint CCR_WD_UNIT_S = 40;
    localparam longint CCR_CLK_HZ = 20000000;
    localparam logic [31:0] CCR_WD_UNIT_CYCLES = 32'(CCR_WD_UNIT_S * CCR_CLK_HZ);

    typedef enum logic [3:0] {
        CCR_IDLE = 4'h0,
        CCR_ADDR = 4'h1,
        CCR_ACK_ADDR = 4'h3,
        CCR_PTR = 4'h2,
        CCR_ACK_PTR = 4'h6,
        CCR_WR = 4'h7,
        CCR_ACK_WR = 4'h5,
        CCR_RD = 4'h4,
        CCR_ACK_RD = 4'hC
    } ccr_i2c_t;

    typedef struct packed {
        logic [5:0] fast_charge_current_code;
        logic [3:0] discharge_limit_code;
        logic [3:0] termination_current_code;
        logic [5:0] cv_code;
        logic precharge_sel;
        logic recharge_offset_sel;
        logic discharge_watchdog_enable;
        logic [1:0] wd_period;
        logic term_enable;
        logic safety_timer_enable;
        logic [1:0] charge_time_limit;
        logic post_termination_charge_keep;
    } ccr_cfg_t;

    typedef struct packed {
        ccr_i2c_t fsm;
        logic scl_q;
        logic sda_q;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic [7:0] ptr;
        logic oe;
        logic [7:0] r_chg;
        logic [7:0] r_dterm;
        logic [7:0] r_volt;
        logic [7:0] r_wdt;
        logic fault;
        logic [31:0] wd_cnt;
        ccr_cfg_t cfg;
    } ccr_state_t;
endpackage

/* File: hw/ccr_regs.sv */
/*
 * Charger configuration registers behind a serial two-wire slave, with the
 * host-activity watchdog, software reset and watchdog fault flag.
 * Assumes SCL and SDA_IN are synchronous to CORE_CLK and slow against it;
 * the pad combines SDA_OUT/SDA_OE (open drain) with the bus pull-up.
 */
`timescale 1ns/1ns
module ccr_regs #(
    parameter logic [31:0] WD_UNIT_CYCLES = ccr_pkg::CCR_WD_UNIT_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic DISCHARGING,
    output ccr_pkg::ccr_cfg_t CFG,
    output logic WD_FAULT
);
    import ccr_pkg::*;

    logic [1:0] rst_sync_reg;
    logic rst_n;
    ccr_state_t st_reg;
    ccr_state_t st_next;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic rd_status;
    logic wd_on;
    logic wd_kick;
    logic wd_expire;
    logic [31:0] wd_limit;

    // only a constant enters under the asynchronous reset
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    function automatic logic [7:0] rd_mux(input ccr_state_t s, input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            CCR_OFS_CHG: d = s.r_chg;
            CCR_OFS_DTERM: d = s.r_dterm;
            CCR_OFS_VOLT: d = s.r_volt;
            CCR_OFS_WDT: d = s.r_wdt;
            CCR_OFS_STAT: d[CCR_FAULT_BIT] = s.fault;
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    assign rise = SCL & ~st_reg.scl_q;
    assign fall = ~SCL & st_reg.scl_q;
    assign start = SCL & st_reg.scl_q & st_reg.sda_q & ~SDA_IN;
    assign stop = SCL & st_reg.scl_q & ~st_reg.sda_q & SDA_IN;

    always_comb begin
        st_next = st_reg;
        wr_en = 1'b0;
        wr_addr = st_reg.ptr;
        wr_data = st_reg.shift;
        rd_status = 1'b0;
        wd_kick = 1'b0;
        wd_expire = 1'b0;
        wd_limit = WD_UNIT_CYCLES;
        st_next.scl_q = SCL;
        st_next.sda_q = SDA_IN;
        // serial side: bits in on SCL rise, drive changes on SCL fall
        if (start) begin
            st_next.fsm = CCR_ADDR;
            st_next.cnt = 4'h0;
            st_next.oe = 1'b0;
        end else if (stop) begin
            st_next.fsm = CCR_IDLE;
            st_next.oe = 1'b0;
        end else if (rise) begin
            st_next.shift = {st_reg.shift[6:0], SDA_IN};
            st_next.cnt = st_reg.cnt + 4'h1;
        end else if (fall) begin
            unique case (st_reg.fsm)
                CCR_IDLE: st_next.fsm = CCR_IDLE;
                CCR_ADDR: begin
                    if (st_reg.cnt == 4'h8) begin
                        if (st_reg.shift[7:1] == CCR_SLAVE_ADDR) begin
                            st_next.fsm = CCR_ACK_ADDR;
                            st_next.oe = 1'b1;
                            wd_kick = 1'b1;
                        end else begin
                            st_next.fsm = CCR_IDLE;
                        end
                    end
                end
                CCR_ACK_ADDR: begin
                    st_next.cnt = 4'h0;
                    // the ack bit has already shifted in, so the direction bit sits one place up
                    if (st_reg.shift[1]) begin
                        st_next.fsm = CCR_RD;
                        st_next.tx = rd_mux(st_reg, st_reg.ptr);
                        st_next.oe = ~st_next.tx[7];
                        rd_status = st_reg.ptr == CCR_OFS_STAT;
                    end else begin
                        st_next.fsm = CCR_PTR;
                        st_next.oe = 1'b0;
                    end
                end
                CCR_PTR: begin
                    if (st_reg.cnt == 4'h8) begin
                        st_next.ptr = st_reg.shift;
                        st_next.fsm = CCR_ACK_PTR;
                        st_next.oe = 1'b1;
                    end
                end
                CCR_ACK_PTR, CCR_ACK_WR: begin
                    st_next.fsm = CCR_WR;
                    st_next.cnt = 4'h0;
                    st_next.oe = 1'b0;
                end
                CCR_WR: begin
                    if (st_reg.cnt == 4'h8) begin
                        wr_en = 1'b1;
                        st_next.ptr = st_reg.ptr + 8'h01;
                        st_next.fsm = CCR_ACK_WR;
                        st_next.oe = 1'b1;
                    end
                end
                CCR_RD: begin
                    if (st_reg.cnt == 4'h8) begin
                        st_next.fsm = CCR_ACK_RD;
                        st_next.oe = 1'b0;
                        st_next.ptr = st_reg.ptr + 8'h01;
                    end else begin
                        st_next.tx = {st_reg.tx[6:0], 1'b0};
                        st_next.oe = ~st_reg.tx[6];
                    end
                end
                CCR_ACK_RD: begin
                    st_next.cnt = 4'h0;
                    // master nack ends the read; wait for stop
                    if (st_reg.shift[0]) begin
                        st_next.fsm = CCR_IDLE;
                    end else begin
                        st_next.fsm = CCR_RD;
                        st_next.tx = rd_mux(st_reg, st_reg.ptr);
                        st_next.oe = ~st_next.tx[7];
                        rd_status = st_reg.ptr == CCR_OFS_STAT;
                    end
                end
            endcase
        end

        // watchdog
        if (wr_en && wr_addr == CCR_OFS_CHG && wr_data[CCR_KICK_BIT]) begin
            wd_kick = 1'b1;
        end
        wd_on = (st_reg.r_wdt[CCR_WDPER_LSB+:2] != 2'h0)
            && (!DISCHARGING || st_reg.r_wdt[CCR_WDDIS_BIT]);
        unique case (st_reg.r_wdt[CCR_WDPER_LSB+:2])
            2'h2: wd_limit = {WD_UNIT_CYCLES[30:0], 1'b0};
            2'h3: wd_limit = {WD_UNIT_CYCLES[29:0], 2'h0};
            default: wd_limit = WD_UNIT_CYCLES;
        endcase
        if (!wd_on || wd_kick) begin
            st_next.wd_cnt = 32'h0;
        end else if (st_reg.wd_cnt >= wd_limit - 32'h1) begin
            wd_expire = 1'b1;
            st_next.wd_cnt = 32'h0;
        end else begin
            st_next.wd_cnt = st_reg.wd_cnt + 32'h1;
        end

        // fault flag: read clears, expiry in the same cycle wins
        if (rd_status) begin
            st_next.fault = 1'b0;
        end
        if (wd_expire) begin
            st_next.fault = 1'b1;
            // period and discharge enable survive expiry
            st_next.r_chg[5:0] = CCR_RST_CHG[5:0];
            st_next.r_dterm = CCR_RST_DTERM;
            st_next.r_volt = CCR_RST_VOLT;
            st_next.r_wdt[4:0] = CCR_RST_WDT[4:0];
        end

        // host write lands after expiry so a fresh setting is kept
        if (wr_en) begin
            unique case (wr_addr)
                CCR_OFS_CHG: begin
                    if (wr_data[CCR_SWRST_BIT]) begin
                        st_next.r_chg = CCR_RST_CHG;
                        st_next.r_dterm = CCR_RST_DTERM;
                        st_next.r_volt = CCR_RST_VOLT;
                        st_next.r_wdt = CCR_RST_WDT;
                    end else begin
                        st_next.r_chg = {2'h0, wr_data[5:0]};
                    end
                end
                CCR_OFS_DTERM: begin
                    st_next.r_dterm[3:0] = wr_data[3:0];
                    // an invalid limit code is refused, old limit kept
                    if (wr_data[7:4] != CCR_DLIM_BAD) begin
                        st_next.r_dterm[7:4] = wr_data[7:4];
                    end
                end
                CCR_OFS_VOLT: st_next.r_volt = wr_data;
                CCR_OFS_WDT: st_next.r_wdt = wr_data;
                default: st_next.r_wdt = st_next.r_wdt;
            endcase
        end

        // settings handed to the charge logic
        st_next.cfg.fast_charge_current_code = (st_next.r_chg[5:0] > CCR_ICHG_MAX)
            ? CCR_ICHG_MAX : st_next.r_chg[5:0];
        st_next.cfg.discharge_limit_code = st_next.r_dterm[7:4];
        st_next.cfg.termination_current_code = st_next.r_dterm[3:0];
        st_next.cfg.cv_code = st_next.r_volt[7:2];
        st_next.cfg.precharge_sel = st_next.r_volt[1];
        st_next.cfg.recharge_offset_sel = st_next.r_volt[0];
        st_next.cfg.discharge_watchdog_enable = st_next.r_wdt[CCR_WDDIS_BIT];
        st_next.cfg.wd_period = st_next.r_wdt[CCR_WDPER_LSB+:2];
        st_next.cfg.term_enable = st_next.r_wdt[CCR_TERM_BIT];
        st_next.cfg.safety_timer_enable = st_next.r_wdt[CCR_TIMER_BIT];
        st_next.cfg.charge_time_limit = st_next.r_wdt[CCR_CTIME_LSB+:2];
        st_next.cfg.post_termination_charge_keep = st_next.r_wdt[CCR_KEEP_BIT];
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.fsm <= CCR_IDLE;
            st_reg.scl_q <= 1'b1;
            st_reg.sda_q <= 1'b1;
            st_reg.r_chg <= CCR_RST_CHG;
            st_reg.r_dterm <= CCR_RST_DTERM;
            st_reg.r_volt <= CCR_RST_VOLT;
            st_reg.r_wdt <= CCR_RST_WDT;
            st_reg.cfg <= {CCR_RST_CHG[5:0], CCR_RST_DTERM, CCR_RST_VOLT, CCR_RST_WDT[7:0]};
        end else begin
            st_reg <= st_next;
        end
    end

    assign SDA_OUT = 1'b0;
    assign SDA_OE = st_reg.oe;
    assign CFG = st_reg.cfg;
    assign WD_FAULT = st_reg.fault;

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!rst_n);

    a_swrst_restores: assert property (wr_en && wr_addr == CCR_OFS_CHG && wr_data[7]
        |=> st_reg.r_chg == CCR_RST_CHG && st_reg.r_wdt == CCR_RST_WDT && st_reg.r_volt == CCR_RST_VOLT)
        else $error("software reset left a field off default");
    a_kick_restarts: assert property (wr_en && wr_addr == CCR_OFS_CHG && wr_data[6]
        |=> st_reg.wd_cnt == 32'h0)
        else $error("watchdog kick did not restart counter");
    a_code_written: assert property (wr_en && wr_addr == CCR_OFS_CHG && !wr_data[7]
        && wr_data[5:0] <= 6'h38 ##1 !wd_expire |-> CFG.fast_charge_current_code == $past(wr_data[5:0], 1))
        else $error("fast charge code not applied");
    a_code_clamped: assert property (st_reg.r_chg[5:0] > 6'h38 |-> CFG.fast_charge_current_code == 6'h38)
        else $error("fast charge code not clamped");
    a_dlim_nonzero: assert property (CFG.discharge_limit_code != 4'h0)
        else $error("discharge limit code zero");
    a_wd_off_idle: assert property ((CFG.wd_period == 2'h0) [*2] |-> st_reg.wd_cnt == 32'h0)
        else $error("watchdog counted while disabled");
    a_dischg_wd_hold: assert property (DISCHARGING && !st_reg.r_wdt[7] |=> st_reg.wd_cnt == 32'h0)
        else $error("watchdog ran in discharge without enable");
    a_expiry_restore: assert property (wd_expire && !wr_en
        |=> st_reg.r_volt == CCR_RST_VOLT && st_reg.r_dterm == CCR_RST_DTERM
        && st_reg.r_wdt[7:5] == $past(st_reg.r_wdt[7:5]) && WD_FAULT)
        else $error("watchdog expiry restore wrong");
    a_fault_sticky: assert property (WD_FAULT && !rd_status |=> WD_FAULT)
        else $error("fault flag dropped without read");
    a_cmd_selfclear: assert property (##1 st_reg.r_chg[7:6] == 2'h0)
        else $error("command bits read back set");
    a_ctrl_written: assert property (wr_en && wr_addr == CCR_OFS_WDT ##1 !wd_expire
        |-> CFG.term_enable == $past(wr_data[4]) && CFG.charge_time_limit == $past(wr_data[2:1]))
        else $error("control bits not applied");
    a_term_written: assert property (wr_en && wr_addr == CCR_OFS_DTERM
        |=> CFG.termination_current_code == $past(wr_data[3:0]))
        else $error("termination code not applied");
    a_dlim_refused: assert property (wr_en && wr_addr == CCR_OFS_DTERM && wr_data[7:4] == 4'h0
        && !wd_expire |=> CFG.discharge_limit_code == $past(st_reg.r_dterm[7:4]))
        else $error("zero discharge limit code was taken");
    a_volt_written: assert property (wr_en && wr_addr == CCR_OFS_VOLT
        |=> CFG.cv_code == $past(wr_data[7:2]) && CFG.precharge_sel == $past(wr_data[1])
        && CFG.recharge_offset_sel == $past(wr_data[0]))
        else $error("voltage settings not applied");
    a_keep_written: assert property (wr_en && wr_addr == CCR_OFS_WDT
        |=> CFG.post_termination_charge_keep == $past(wr_data[0]) && CFG.safety_timer_enable == $past(wr_data[3]))
        else $error("keep or timer enable not applied");
    a_code_ceiling: assert property (CFG.fast_charge_current_code <= 6'h38)
        else $error("effective charge code above ceiling");
    a_wd_expires: assert property (wd_on && !wd_kick && st_reg.wd_cnt == wd_limit - 32'h1
        |=> WD_FAULT && st_reg.wd_cnt == 32'h0)
        else $error("watchdog did not expire at its limit");
    a_period_double: assert property (st_reg.r_wdt[6:5] == 2'h2 |-> wd_limit == WD_UNIT_CYCLES * 32'h2)
        else $error("watchdog limit wrong for middle period");
    a_period_quad: assert property (st_reg.r_wdt[6:5] == 2'h3 |-> wd_limit == WD_UNIT_CYCLES * 32'h4)
        else $error("watchdog limit wrong for longest period");
    a_period_kept: assert property (wd_expire && !wr_en
        |=> CFG.wd_period == $past(st_reg.r_wdt[6:5]) && CFG.discharge_watchdog_enable == $past(st_reg.r_wdt[7]))
        else $error("watchdog expiry touched period or discharge enable");
    a_fault_clear: assert property (rd_status && !wd_expire |=> !WD_FAULT)
        else $error("status read left fault flag set");

    c_kick: cover property (wr_en && wr_addr == CCR_OFS_CHG && wr_data[6]);
    c_expire: cover property (wd_expire);
    c_status_read: cover property (rd_status && st_reg.fault);
    c_swrst: cover property (wr_en && wr_addr == CCR_OFS_CHG && wr_data[7]);
    c_burst_read: cover property (st_reg.fsm == CCR_ACK_RD && fall && !st_reg.shift[0]);
endmodule
